// ===== rtl/clockgen_altpmd_config_regs.sv
// clock generator, alternate medium and loop filter configuration registers
`timescale 1ns/100ps

module clockgen_altpmd_config_regs
#(
    // revision dependent reset choice; later parts pick their own filter
    parameter bit         EARLY_REVISION        = 1'b1,
    parameter logic [2:0] LATE_FILTER_RESET     = clockgen_cfg_pkg::FILTER_POSITION_TWO_CODE
)
(
    // clock and reset
    input  wire logic                             ref_clk,
    input  wire logic                             reset_n,
    // control port, synchronous to ref_clk
    input  wire clockgen_cfg_pkg::ctrl_access_t   ctrl_access,
    output logic      [7:0]                       ctrl_rdata_r,
    output logic                                  ctrl_rvalid_r,
    // configuration outputs
    output clockgen_cfg_pkg::clock_cfg_t          clock_cfg_r,
    output logic                                  tx_clock_outputs_en_r,
    output logic                                  loop_filter_diag_pin_en_r,
    output logic                                  alt_recv_clock_out_en_r,
    output logic                                  alt_recv_clock_in_en_r,
    // decoded loop filter position
    output logic      [2:0]                       filter_position_r,
    output logic                                  filter_code_legal_r
);
    import clockgen_cfg_pkg::*;

    // ****************************************
    // reset value of the filter select field
    // ****************************************
    // early parts come up on position two
    localparam logic [2:0] FILTER_RESET =
        EARLY_REVISION ? FILTER_POSITION_TWO_CODE : LATE_FILTER_RESET;

    clock_cfg_t  clock_cfg_nxt;
    logic [7:0]  ctrl_rdata_nxt;
    logic        ctrl_rvalid_nxt;
    logic        tx_clock_outputs_en_nxt;
    logic        loop_filter_diag_pin_en_nxt;
    logic        alt_recv_clock_out_en_nxt;
    logic        alt_recv_clock_in_en_nxt;

    // ****************************************
    // register image as software reads it
    // ****************************************
    function automatic logic [7:0] read_image
    (
        input logic [5:0] addr,
        input clock_cfg_t cfg
    );
        logic [7:0] img;
        img = UNMAPPED_READ_VALUE;
        case (addr)
            CLOCK_GEN_OUTPUT_CONTROL_ADDR:
            begin
                // reserved bits read their reset pattern
                img = CLK_GEN_RESERVED_RESET & CLK_GEN_RESERVED_MASK;
                img[TX_CLOCK_OUT_ENABLE_BIT]        = cfg.tx_clock_out_enable;
                img[FILTER_NODE_OBSERVE_ENABLE_BIT] = cfg.filter_node_observe_enable;
            end
            ALTERNATE_MEDIUM_INTERFACE_CONTROL_ADDR:
            begin
                img = ALT_RESERVED_RESET & ALT_RESERVED_MASK;
                img[ALTERNATE_INTERFACE_ENABLE_BIT] = cfg.alternate_interface_enable;
            end
            LOOP_FILTER_GAIN_SELECT_ADDR:
            begin
                img = GAIN_RESERVED_RESET & GAIN_RESERVED_MASK;
                img[FILTER_SELECT_LSB +: FILTER_SELECT_W] = cfg.filter_select;
            end
            default:
            begin
                img = UNMAPPED_READ_VALUE;
            end
        endcase
        return img;
    endfunction

    // ****************************************
    // read answers
    // ****************************************
    // a read in the same cycle as a write returns the old value
    always_comb
    begin
        ctrl_rvalid_nxt = ctrl_access.rd;
        ctrl_rdata_nxt  = ctrl_rdata_r;
        if (ctrl_access.rd)
        begin
            // reserved positions read their reset pattern
            ctrl_rdata_nxt = read_image(ctrl_access.addr, clock_cfg_r);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_rdata_r  <= 8'h00;
            ctrl_rvalid_r <= 1'b0;
        end
        else
        begin
            ctrl_rdata_r  <= ctrl_rdata_nxt;
            ctrl_rvalid_r <= ctrl_rvalid_nxt;
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    always_comb
    begin
        clock_cfg_nxt = clock_cfg_r;
        if (ctrl_access.wr)
        begin
            // reserved positions are not stored, so a write-back cannot disturb them
            case (ctrl_access.addr)
                CLOCK_GEN_OUTPUT_CONTROL_ADDR:
                begin
                    clock_cfg_nxt.tx_clock_out_enable =
                        ctrl_access.wdata[TX_CLOCK_OUT_ENABLE_BIT];
                    clock_cfg_nxt.filter_node_observe_enable =
                        ctrl_access.wdata[FILTER_NODE_OBSERVE_ENABLE_BIT];
                end
                ALTERNATE_MEDIUM_INTERFACE_CONTROL_ADDR:
                begin
                    clock_cfg_nxt.alternate_interface_enable =
                        ctrl_access.wdata[ALTERNATE_INTERFACE_ENABLE_BIT];
                end
                LOOP_FILTER_GAIN_SELECT_ADDR:
                begin
                    clock_cfg_nxt.filter_select =
                        ctrl_access.wdata[FILTER_SELECT_LSB +: FILTER_SELECT_W];
                end
                default:
                begin
                    clock_cfg_nxt = clock_cfg_r;
                end
            endcase
        end
    end

    // ****************************************
    // pin enables follow the stored bits
    // ****************************************
    always_comb
    begin
        // clock outputs from the enable bit only
        // alternate enable does not touch the clock outputs
        tx_clock_outputs_en_nxt     = clock_cfg_nxt.tx_clock_out_enable;
        loop_filter_diag_pin_en_nxt = clock_cfg_nxt.filter_node_observe_enable;
        // extra receive clock output and input enables
        alt_recv_clock_out_en_nxt   = clock_cfg_nxt.alternate_interface_enable;
        alt_recv_clock_in_en_nxt    = clock_cfg_nxt.alternate_interface_enable;
    end

    // pins switch with the stored bits, no extra cycle
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_clock_outputs_en_r     <= 1'b0;
            loop_filter_diag_pin_en_r <= 1'b0;
            alt_recv_clock_out_en_r   <= 1'b0;
            alt_recv_clock_in_en_r    <= 1'b0;
        end
        else
        begin
            tx_clock_outputs_en_r     <= tx_clock_outputs_en_nxt;
            loop_filter_diag_pin_en_r <= loop_filter_diag_pin_en_nxt;
            alt_recv_clock_out_en_r   <= alt_recv_clock_out_en_nxt;
            alt_recv_clock_in_en_r    <= alt_recv_clock_in_en_nxt;
        end
    end

    // ****************************************
    // stored configuration
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clock_cfg_r.tx_clock_out_enable        <= 1'b0;
            clock_cfg_r.filter_node_observe_enable <= 1'b0;
            clock_cfg_r.alternate_interface_enable <= 1'b0;
            clock_cfg_r.filter_select              <= FILTER_RESET;
        end
        else
        begin
            clock_cfg_r <= clock_cfg_nxt;
        end
    end

    // ****************************************
    // filter position decode
    // ****************************************
    // decode lags the stored code by one cycle
    filter_position_decode u_filter_position_decode
    (
        .ref_clk             (ref_clk),
        .reset_n             (reset_n),
        .filter_select       (clock_cfg_r.filter_select),
        .filter_position_r   (filter_position_r),
        .filter_code_legal_r (filter_code_legal_r)
    );

endmodule

// ===== rtl/clockgen_cfg_pkg.sv
// constants and types for the clock generator configuration registers
package clockgen_cfg_pkg;

    // ****************************************
    // register addresses on the control port
    // ****************************************
    localparam int          ADDR_W                = 6;
    localparam logic [5:0]  CLOCK_GEN_OUTPUT_CONTROL_ADDR          = 6'h3b;
    localparam logic [5:0]  ALTERNATE_MEDIUM_INTERFACE_CONTROL_ADDR = 6'h3c;
    localparam logic [5:0]  LOOP_FILTER_GAIN_SELECT_ADDR           = 6'h3d;

    // ****************************************
    // field positions
    // ****************************************
    localparam int TX_CLOCK_OUT_ENABLE_BIT        = 3;
    localparam int FILTER_NODE_OBSERVE_ENABLE_BIT = 5;
    localparam int ALTERNATE_INTERFACE_ENABLE_BIT = 3;
    localparam int FILTER_SELECT_LSB              = 5;
    localparam int FILTER_SELECT_W                = 3;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] CLK_GEN_RESERVED_RESET = 8'h00;
    localparam logic [7:0] ALT_RESERVED_RESET     = 8'h00;
    localparam logic [7:0] GAIN_RESERVED_RESET    = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE    = 8'h00;
    localparam logic [7:0] CLK_GEN_RESERVED_MASK  = 8'hd7;
    localparam logic [7:0] ALT_RESERVED_MASK   = 8'hf7;
    localparam logic [7:0] GAIN_RESERVED_MASK  = 8'h1f;

    // ****************************************
    // loop filter select codes
    // ****************************************
    localparam logic [2:0] FILTER_POSITION_ZERO_CODE  = 3'h6;
    localparam logic [2:0] FILTER_POSITION_ONE_CODE   = 3'h7;
    localparam logic [2:0] FILTER_POSITION_TWO_CODE   = 3'h0;
    localparam logic [2:0] FILTER_POSITION_THREE_CODE = 3'h1;
    localparam logic [2:0] FILTER_POSITION_FOUR_CODE  = 3'h2;

    // configuration bits that steer the rest of the device
    typedef struct packed {
        logic       tx_clock_out_enable;
        logic       filter_node_observe_enable;
        logic       alternate_interface_enable;
        logic [2:0] filter_select;
    } clock_cfg_t;

    // one control port access
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } ctrl_access_t;

endpackage

// ===== rtl/filter_position_decode.sv
// registered decode of the loop filter select code into a position number
`timescale 1ns/100ps
module filter_position_decode
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // select code in
    input  wire logic [2:0] filter_select,
    // decoded position out
    output logic      [2:0] filter_position_r,
    output logic            filter_code_legal_r
);
    import clockgen_cfg_pkg::*;

    logic [2:0] filter_position_nxt;
    logic       filter_code_legal_nxt;

    // ****************************************
    // code to position
    // ****************************************
    // five legal codes
    always_comb
    begin
        filter_code_legal_nxt = 1'b1;
        case (filter_select)
            FILTER_POSITION_ZERO_CODE:  filter_position_nxt = 3'h0;
            FILTER_POSITION_ONE_CODE:   filter_position_nxt = 3'h1;
            FILTER_POSITION_TWO_CODE:   filter_position_nxt = 3'h2;
            FILTER_POSITION_THREE_CODE: filter_position_nxt = 3'h3;
            FILTER_POSITION_FOUR_CODE:  filter_position_nxt = 3'h4;
            default:
            begin
                // unlisted codes keep the loop on position two
                filter_position_nxt   = 3'h2;
                filter_code_legal_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            filter_position_r   <= 3'h2;
            filter_code_legal_r <= 1'b1;
        end
        else
        begin
            filter_position_r   <= filter_position_nxt;
            filter_code_legal_r <= filter_code_legal_nxt;
        end
    end

endmodule

// ===== testbench/config_regs_checker.sv
// concurrent checks on the configuration register block ports
`timescale 1ns/100ps
module config_regs_checker
#(
    parameter bit         EARLY_REVISION    = 1'b1,
    parameter logic [2:0] LATE_FILTER_RESET = 3'h0
)
(
    // clock and reset
    input wire logic                           ref_clk,
    input wire logic                           reset_n,
    // control port
    input wire clockgen_cfg_pkg::ctrl_access_t ctrl_access,
    input wire logic [7:0]                     ctrl_rdata_r,
    input wire logic                           ctrl_rvalid_r,
    // configuration outputs
    input wire clockgen_cfg_pkg::clock_cfg_t   clock_cfg_r,
    input wire logic                           tx_clock_outputs_en_r,
    input wire logic                           loop_filter_diag_pin_en_r,
    input wire logic                           alt_recv_clock_out_en_r,
    input wire logic                           alt_recv_clock_in_en_r,
    input wire logic [2:0]                     filter_position_r,
    input wire logic                           filter_code_legal_r
);
    import clockgen_cfg_pkg::*;
    // position per select code; unlisted codes fall back to position two
    localparam logic [2:0] POS_OF [8] = '{3'h2, 3'h3, 3'h4, 3'h2, 3'h2, 3'h2, 3'h0, 3'h1};
    localparam logic [2:0] RST_FILT = EARLY_REVISION ? 3'h0 : LATE_FILTER_RESET;
    logic w3b, w3c, w3d, r3b, r3d;
    assign w3b = ctrl_access.wr && ctrl_access.addr == CLOCK_GEN_OUTPUT_CONTROL_ADDR;
    assign w3c = ctrl_access.wr && ctrl_access.addr == ALTERNATE_MEDIUM_INTERFACE_CONTROL_ADDR;
    assign w3d = ctrl_access.wr && ctrl_access.addr == LOOP_FILTER_GAIN_SELECT_ADDR;
    assign r3b = ctrl_access.rd && ctrl_access.addr == CLOCK_GEN_OUTPUT_CONTROL_ADDR;
    assign r3d = ctrl_access.rd && ctrl_access.addr == LOOP_FILTER_GAIN_SELECT_ADDR;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_tx_write;
        w3b |=> tx_clock_outputs_en_r == $past(ctrl_access.wdata[3]);
    endproperty
    a_tx_write: assert property (p_tx_write) else $error("tx clock enable wrong");
    property p_obs_write;
        w3b |=> loop_filter_diag_pin_en_r == $past(ctrl_access.wdata[5]);
    endproperty
    a_obs_write: assert property (p_obs_write) else $error("observe pin wrong");
    property p_alt_write;
        w3c |=> alt_recv_clock_out_en_r == $past(ctrl_access.wdata[3])
            && alt_recv_clock_in_en_r == $past(ctrl_access.wdata[3]);
    endproperty
    a_alt_write: assert property (p_alt_write) else $error("alt enable wrong");
    property p_alt_no_tx;
        w3c |=> $stable(tx_clock_outputs_en_r);
    endproperty
    a_alt_no_tx: assert property (p_alt_no_tx) else $error("alt write moved tx");
    property p_filt_write;
        w3d |=> clock_cfg_r.filter_select == $past(ctrl_access.wdata[7:5]);
    endproperty
    a_filt_write: assert property (p_filt_write) else $error("filter select wrong");
    property p_filt_pos;
        w3d |=> ##1 filter_position_r == POS_OF[$past(ctrl_access.wdata[7:5], 2)];
    endproperty
    a_filt_pos: assert property (p_filt_pos) else $error("filter position wrong");
    property p_reset_state;
        $rose(reset_n) |-> !tx_clock_outputs_en_r && !loop_filter_diag_pin_en_r
            && !alt_recv_clock_out_en_r && clock_cfg_r.filter_select == RST_FILT;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
    property p_read_clock_gen;
        r3b |=> ctrl_rvalid_r && ctrl_rdata_r == {2'h0, $past(clock_cfg_r.filter_node_observe_enable),
            1'b0, $past(clock_cfg_r.tx_clock_out_enable), 3'h0};
    endproperty
    a_read_clock_gen: assert property (p_read_clock_gen) else $error("control read wrong");
    property p_read_gain;
        r3d |=> ctrl_rvalid_r && ctrl_rdata_r == {$past(clock_cfg_r.filter_select), 5'h00};
    endproperty
    a_read_gain: assert property (p_read_gain) else $error("gain read wrong");

    cover property (w3b ##1 tx_clock_outputs_en_r);
    cover property (w3d ##2 filter_position_r == 3'h4);
    cover property (w3c ##1 alt_recv_clock_out_en_r);
endmodule

bind clockgen_altpmd_config_regs config_regs_checker #(.EARLY_REVISION(EARLY_REVISION),
    .LATE_FILTER_RESET(LATE_FILTER_RESET)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .ctrl_access(ctrl_access), .ctrl_rdata_r(ctrl_rdata_r), .ctrl_rvalid_r(ctrl_rvalid_r),
    .clock_cfg_r(clock_cfg_r), .tx_clock_outputs_en_r(tx_clock_outputs_en_r),
    .loop_filter_diag_pin_en_r(loop_filter_diag_pin_en_r),
    .alt_recv_clock_out_en_r(alt_recv_clock_out_en_r),
    .alt_recv_clock_in_en_r(alt_recv_clock_in_en_r), .filter_position_r(filter_position_r),
    .filter_code_legal_r(filter_code_legal_r));

// ===== testbench/clockgen_altpmd_config_regs_tb_top.sv
// self-checking bench for the configuration register block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module clockgen_altpmd_config_regs_tb_top;
    import clockgen_cfg_pkg::*;
    logic         ref_clk     = 1'b0;
    logic         reset_n     = 1'b0;
    ctrl_access_t ctrl_access = '0;
    logic [7:0]   ctrl_rdata_r;
    logic         ctrl_rvalid_r, tx_en, diag_en, alt_out, alt_in, legal;
    clock_cfg_t   clock_cfg_r;
    logic [2:0]   fpos;
    logic [7:0]   gain_img;
    logic [2:0]   codes [5]   = '{3'h6, 3'h7, 3'h0, 3'h1, 3'h2};
    int           miscompares = 0;
    int           n_compared  = 0;

    always #5 ref_clk = ~ref_clk;

    clockgen_altpmd_config_regs dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .ctrl_access(ctrl_access), .ctrl_rdata_r(ctrl_rdata_r), .ctrl_rvalid_r(ctrl_rvalid_r),
        .clock_cfg_r(clock_cfg_r), .tx_clock_outputs_en_r(tx_en),
        .loop_filter_diag_pin_en_r(diag_en), .alt_recv_clock_out_en_r(alt_out),
        .alt_recv_clock_in_en_r(alt_in), .filter_position_r(fpos), .filter_code_legal_r(legal));

    // ****************************************
    // access tasks, one idle cycle after wr, two after rd
    // ****************************************
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        ctrl_access = '{1'b1, 1'b0, a, d};
        @(negedge ref_clk);
        ctrl_access = '0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        ctrl_access = '{1'b0, 1'b1, a, 8'h00};
        @(negedge ref_clk);
        ctrl_access = '0;
        `CHK("read valid", 1'b1, ctrl_rvalid_r)
        `CHK("read data", e, ctrl_rdata_r)
        // valid is a one-cycle pulse
        @(negedge ref_clk);
        `CHK("read valid drop", 1'b0, ctrl_rvalid_r)
    endtask
    task automatic pins(input logic tx, input logic dg, input logic alt);
        `CHK("tx enable", tx, tx_en)
        `CHK("diag enable", dg, diag_en)
        `CHK("alt out enable", alt, alt_out)
        `CHK("alt in enable", alt, alt_in)
        `CHK("cfg tx bit", tx, clock_cfg_r.tx_clock_out_enable)
        `CHK("cfg observe bit", dg, clock_cfg_r.filter_node_observe_enable)
        `CHK("cfg alt bit", alt, clock_cfg_r.alternate_interface_enable)
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        pins(1'b0, 1'b0, 1'b0);
        `CHK("filter position", 3'h2, fpos)
        rd(6'h3b, 8'h00);
        rd(6'h3c, 8'h00);
        rd(6'h3d, 8'h00);
        $display("test reset defaults done");
        wr(6'h3b, 8'hff);
        pins(1'b1, 1'b1, 1'b0);
        rd(6'h3b, 8'h28);
        // tx clock enable only, observe pin switched off
        wr(6'h3b, 8'h08);
        pins(1'b1, 1'b0, 1'b0);
        wr(6'h3b, 8'h00);
        pins(1'b0, 1'b0, 1'b0);
        // long loopback lives elsewhere, never selected here
        wr(6'h3c, 8'hff);
        pins(1'b0, 1'b0, 1'b1);
        rd(6'h3c, 8'h08);
        wr(6'h3c, 8'h00);
        pins(1'b0, 1'b0, 1'b0);
        $display("test enables done");
        // unlisted code falls back to position two
        wr(6'h3d, 8'h60);
        @(negedge ref_clk);
        `CHK("illegal legal", 1'b0, legal)
        `CHK("illegal position", 3'h2, fpos)
        for (int i = 0; i < 5; i++)
        begin
            wr(6'h3d, {codes[i], 5'h1f});
            `CHK("filter select", codes[i], clock_cfg_r.filter_select)
            @(negedge ref_clk);
            `CHK("filter position", i[2:0], fpos)
            `CHK("filter legal", 1'b1, legal)
            rd(6'h3d, {codes[i], 5'h00});
        end
        $display("test filter codes done");
        wr(6'h3e, 8'hff);
        rd(6'h3e, 8'h00);
        rd(6'h3b, 8'h00);
        wr(6'h3b, 8'hff);
        wr(6'h3c, 8'hff);
        pins(1'b1, 1'b1, 1'b1);
        // reset in mid-run must restore every default
        reset_n = 1'b0;
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        pins(1'b0, 1'b0, 1'b0);
        `CHK("filter position", 3'h2, fpos)
        rd(6'h3d, 8'h00);
        // early part, so position four is programmed
        gain_img = (ctrl_rdata_r & GAIN_RESERVED_MASK) | {FILTER_POSITION_FOUR_CODE, 5'h00};
        wr(6'h3d, gain_img);
        @(negedge ref_clk);
        `CHK("position four", 3'h4, fpos)
        rd(6'h3d, 8'h40);
        $display("test unmapped and reset done");
        end_sim;
    end

    // hang guard, far beyond the hundred or so cycles the tests need
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        end_sim;
    end
endmodule
